// file: design/mop_pkg.sv
// constants and state types for the misc-options and strap-override register pair
// Contract
// RULE1: bit 15 set rejects frames lacking checksum
// RULE2: bit 14 reloads boot setpoint on shutdown
// RULE3: bit 13 reloads boot setpoint on retry restart
// RULE4: bit 12 picks power-good or reset pin
// RULE5: bit 3 set disables reset-mode pull-up
// RULE6: host writes zero to reserved option bits
// RULE7: bit 2 picks fault tally decrement or clear
// RULE8: bits 1:0 pick 12/10/8/6-bit telemetry
// RULE9: set override keeps strap value; strap at reset
// RULE10: bit 12 selects stacking source
// RULE11: bit 11 selects sync source
// RULE12: bit 9 selects compensation source
// RULE13: bit 8 selects bus address source
// RULE14: bit 5 selects interleave source
// RULE15: bit 3 selects soft-start rise source
// RULE16: host writes zero to unused override bits; the code clears only bits 15:13 and 7:6, so bits 10 and 4 pass through
// RULE17: word access at EDh and EEh, live
// RULE18: bit 2 selects overcurrent limits source
// RULE19: bit 1 selects switching rate source
// RULE20: bit 0 selects output voltage source
// RULE21: bits 11:4 stored only, bit 3 pull-up
package mop_pkg;
   // command codes
   localparam logic [7:0] CMD_MISC = 8'hED;
   localparam logic [7:0] CMD_OVR = 8'hEE;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_OVERRIDE = 8'h21;
   // misc options field positions
   localparam int MISC_PEC = 15;
   localparam int MISC_RST_SD = 14;
   localparam int MISC_RST_FLT = 13;
   localparam int MISC_RESET_FN = 12;
   localparam int MISC_PULLUP_N = 3;
   localparam int MISC_TALLY = 2;
   localparam logic [15:0] MISC_RSVD_MASK = 16'h0FF0;
   localparam logic [15:0] OVR_RSVD_MASK = 16'hE0C0;
   // reset values (stored copy stands in for non-volatile contents)
   localparam logic [15:0] MISC_RESET = 16'h0000;
   localparam logic [15:0] OVR_RESET = 16'h0000;
   localparam logic [15:0] OUTPUT_VOLTAGE_OVERRIDE_RESET = 16'h0000;
   // strap-selected settings, eight bits each
   localparam int NSET = 9;
   localparam int SETW = 8;
   typedef int unsigned mop_bit_t [NSET];
   // stack, sync, comp, address, interleave, rise, overcurrent, rate, voltage
   localparam mop_bit_t OVR_BIT = '{12, 11, 9, 8, 5, 3, 2, 1, 0};
   // host APB register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CODE = 8'h04;
   localparam logic [7:0] A_WDATA = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0C;
   localparam logic [7:0] A_RDATA = 8'h10;
   localparam int C_START = 0;
   localparam int C_WRITE = 1;
   localparam int C_PEC = 2;
   localparam int C_PEC_OK = 3;
   localparam int TALLY_W = 8;
   typedef enum {H_IDLE, H_WAIT} mop_hstate_e;
   typedef struct packed {
      logic [15:0] misc;
      logic [15:0] ovr;
      logic [15:0] output_voltage_override;
      logic [TALLY_W-1:0] tally;
      logic coms_fail;
      logic ack;
      logic nack;
      logic [15:0] rdata;
      logic pin_o;
      logic pin_oe_n;
      logic pullup_en;
      logic [3:0] adc_bits;
   } mop_dev_s;
   typedef struct packed {
      logic [NSET*SETW-1:0] strap;
      logic captured;
      logic booted;
      logic [NSET*SETW-1:0] loaded;
   } mop_sel_s;
   typedef struct packed {
      mop_hstate_e st;
      logic [3:0] ctrl;
      logic [7:0] code;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic done;
      logic nack;
      logic req;
      logic [31:0] prdata;
      logic pslverr;
   } mop_host_s;
endpackage : mop_pkg

// file: design/mop_link_if.sv
// word-transaction link between host controller and converter registers
interface mop_link_if;
   logic req;
   logic wr;
   logic [7:0] code;
   logic [15:0] wdata;
   logic pec_present;
   logic pec_ok;
   logic ack;
   logic nack;
   logic [15:0] rdata;
   modport host (output req, wr, code, wdata, pec_present, pec_ok, input ack, nack, rdata);
   modport dev (input req, wr, code, wdata, pec_present, pec_ok, output ack, nack, rdata);
endinterface : mop_link_if

// file: design/mop_strap_sel.sv
// strap capture and per-setting strap/stored source selection
module mop_strap_sel (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // control
   input wire logic restore_evt,
   input wire logic [15:0] ovr,
   // candidate values
   input wire logic [mop_pkg::NSET*mop_pkg::SETW-1:0] strap_val,
   input wire logic [mop_pkg::NSET*mop_pkg::SETW-1:0] nvm_val,
   // chosen values
   output logic [mop_pkg::NSET*mop_pkg::SETW-1:0] loaded
);
   mop_pkg::mop_sel_s q, d;

   // pick strap or stored per setting from its override bit
   function automatic logic [mop_pkg::NSET*mop_pkg::SETW-1:0] pick(
      input logic [15:0] o, input logic [mop_pkg::NSET*mop_pkg::SETW-1:0] s,
      input logic [mop_pkg::NSET*mop_pkg::SETW-1:0] n);
      logic [mop_pkg::NSET*mop_pkg::SETW-1:0] r;
      r = n;
      for (int i = 0; i < mop_pkg::NSET; i++) begin
         if (o[mop_pkg::OVR_BIT[i]]) begin
            r[i*mop_pkg::SETW +: mop_pkg::SETW] = s[i*mop_pkg::SETW +: mop_pkg::SETW];
         end
      end
      return r;
   endfunction : pick

   // strap caught once after reset, then power-up load, later restores
   always_comb begin
      d = q;
      if (!q.captured) begin
         d.strap = strap_val; // RULE9
         d.captured = 1'b1;
      end else if (!q.booted || restore_evt) begin
         d.booted = 1'b1;
         d.loaded = pick(ovr, q.strap, nvm_val); // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15 RULE18 RULE19 RULE20
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign loaded = q.loaded;
endmodule : mop_strap_sel

// file: design/mop_device.sv
// converter end: option registers, setpoint reload, pin role, fault tally
//
// The implementer's own choice: the APB interface to the registers.
module mop_device (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // link
   mop_link_if.dev link,
   // converter events
   input wire logic shutdown_evt,
   input wire logic fault_restart_evt,
   input wire logic retry_mode,
   input wire logic [15:0] boot_voltage_value,
   input wire logic power_good_output,
   input wire logic reset_request,
   input wire logic pwm_cycle,
   input wire logic pwm_fault,
   input wire logic clr_coms_fail,
   // strap and stored values
   input wire logic restore_evt,
   input wire logic [mop_pkg::NSET*mop_pkg::SETW-1:0] strap_val,
   input wire logic [mop_pkg::NSET*mop_pkg::SETW-1:0] nvm_val,
   // settings out
   output logic [15:0] output_voltage_override_command,
   output logic coms_fail,
   output logic pin_o,
   output logic pin_oe_n,
   output logic pin_pullup_en,
   output logic [1:0] telemetry_resolution,
   output logic [3:0] adc_bits,
   output logic fault_tally_decay_mode,
   output logic [mop_pkg::TALLY_W-1:0] fault_tally,
   output logic [mop_pkg::NSET*mop_pkg::SETW-1:0] loaded_val
);
   mop_pkg::mop_dev_s q, d;
   logic take;
   logic bad_pec;

   // override-driven load of strap or stored settings
   mop_strap_sel u_sel (
      .clock(clock),
      .rst(rst),
      .restore_evt(restore_evt),
      .ovr(q.ovr),
      .strap_val(strap_val),
      .nvm_val(nvm_val),
      .loaded(loaded_val)
   );

   // one request per answer; no new take while an answer is shown
   assign take = link.req && !q.ack && !q.nack;
   assign bad_pec = (q.misc[mop_pkg::MISC_PEC] && !link.pec_present) // RULE1
      || (link.pec_present && !link.pec_ok);

   // next state
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.nack = 1'b0;
      // word read and write of the option registers
      if (take) begin
         if (bad_pec) begin
            d.nack = 1'b1; // RULE1
         end else begin
            unique case (link.code)
               mop_pkg::CMD_MISC: begin
                  d.ack = 1'b1;
                  d.rdata = q.misc;
                  if (link.wr) begin
                     d.misc = link.wdata; // RULE17 RULE21
                  end
               end
               mop_pkg::CMD_OVR: begin
                  d.ack = 1'b1;
                  d.rdata = q.ovr;
                  if (link.wr) begin
                     d.ovr = link.wdata; // RULE17
                  end
               end
               mop_pkg::CMD_OUTPUT_VOLTAGE_OVERRIDE: begin
                  d.ack = 1'b1;
                  d.rdata = q.output_voltage_override;
                  if (link.wr) begin
                     d.output_voltage_override = link.wdata;
                  end
               end
               default: begin
                  d.nack = 1'b1;
               end
            endcase
         end
      end
      // failure flag: set wins over clear
      if (clr_coms_fail) begin
         d.coms_fail = 1'b0;
      end
      if (take && bad_pec) begin
         d.coms_fail = 1'b1; // RULE1
      end
      // setpoint reload to boot value, events override a host write
      if (shutdown_evt && q.misc[mop_pkg::MISC_RST_SD]) begin
         d.output_voltage_override = boot_voltage_value; // RULE2
      end
      if (fault_restart_evt && retry_mode && q.misc[mop_pkg::MISC_RST_FLT]) begin
         d.output_voltage_override = boot_voltage_value; // RULE3
      end
      // fault tally: count faults, decay or clear on clean cycles
      if (pwm_cycle) begin
         if (pwm_fault) begin
            if (q.tally != '1) begin
               d.tally = q.tally + 1'b1;
            end
         end else if (q.misc[mop_pkg::MISC_TALLY]) begin
            d.tally = '0; // RULE7
         end else if (q.tally != '0) begin
            d.tally = q.tally - 1'b1; // RULE7
         end
      end
      // shared status pin: open drain, low-active enable
      d.pin_o = 1'b0;
      if (q.misc[mop_pkg::MISC_RESET_FN]) begin
         d.pin_oe_n = !reset_request; // RULE4
         d.pullup_en = !q.misc[mop_pkg::MISC_PULLUP_N]; // RULE5 RULE21
      end else begin
         d.pin_oe_n = power_good_output; // RULE4
         d.pullup_en = 1'b0; // RULE4
      end
      // telemetry width from resolution code
      unique case (q.misc[1:0])
         2'b00: d.adc_bits = 4'hC; // RULE8
         2'b01: d.adc_bits = 4'hA; // RULE8
         2'b10: d.adc_bits = 4'h8; // RULE8
         2'b11: d.adc_bits = 4'h6; // RULE8
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
         q.misc <= mop_pkg::MISC_RESET;
         q.ovr <= mop_pkg::OVR_RESET;
         q.output_voltage_override <= mop_pkg::OUTPUT_VOLTAGE_OVERRIDE_RESET;
         q.pin_oe_n <= 1'b1;
         q.adc_bits <= 4'hC;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign link.ack = q.ack;
   assign link.nack = q.nack;
   assign link.rdata = q.rdata;
   assign output_voltage_override_command = q.output_voltage_override;
   assign coms_fail = q.coms_fail;
   assign pin_o = q.pin_o;
   assign pin_oe_n = q.pin_oe_n;
   assign pin_pullup_en = q.pullup_en;
   assign telemetry_resolution = q.misc[1:0];
   assign adc_bits = q.adc_bits;
   assign fault_tally_decay_mode = q.misc[mop_pkg::MISC_TALLY];
   assign fault_tally = q.tally;
endmodule : mop_device

// file: design/mop_host.sv
// host end: APB command registers driving word transactions on the link
module mop_host (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   mop_link_if.host link
);
   mop_pkg::mop_host_s q, d;
   logic wr_acc;
   logic rd_acc;

   // clear reserved bits of option writes before they go out
   function automatic logic [15:0] scrub(input logic [7:0] c, input logic [15:0] v);
      logic [15:0] r;
      r = v;
      if (c == mop_pkg::CMD_MISC) begin
         r = v & ~mop_pkg::MISC_RSVD_MASK; // RULE6
      end else if (c == mop_pkg::CMD_OVR) begin
         r = v & ~mop_pkg::OVR_RSVD_MASK; // RULE16
      end
      return r;
   endfunction : scrub

   // writes land at the access edge; read data and error are registered at the
   // setup edge so they stand through the access phase that pready closes
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   // next state
   always_comb begin
      d = q;
      d.pslverr = 1'b0;
      // refuse unmapped offsets and writes to read-only words during setup
      if (psel && !penable) begin
         d.pslverr = !(paddr inside {mop_pkg::A_CTRL, mop_pkg::A_CODE, mop_pkg::A_WDATA,
            mop_pkg::A_STATUS, mop_pkg::A_RDATA}) || (pwrite && paddr inside {mop_pkg::A_STATUS,
            mop_pkg::A_RDATA});
      end
      // register writes
      if (wr_acc) begin
         unique case (paddr)
            mop_pkg::A_CTRL: begin
               d.ctrl = pwdata[3:0];
               d.ctrl[mop_pkg::C_START] = 1'b0;
               if (pwdata[mop_pkg::C_START] && q.st == mop_pkg::H_IDLE) begin
                  d.st = mop_pkg::H_WAIT;
                  d.req = 1'b1; // RULE17
                  d.done = 1'b0;
                  d.nack = 1'b0;
               end
            end
            mop_pkg::A_CODE: d.code = pwdata[7:0];
            mop_pkg::A_WDATA: d.wdata = scrub(q.code, pwdata[15:0]);
            default: ;
         endcase
      end
      // register reads
      d.prdata = '0;
      if (rd_acc) begin
         unique case (paddr)
            mop_pkg::A_CTRL: d.prdata = {28'h0000000, q.ctrl};
            mop_pkg::A_CODE: d.prdata = {24'h000000, q.code};
            mop_pkg::A_WDATA: d.prdata = {16'h0000, q.wdata};
            mop_pkg::A_STATUS: d.prdata = {29'h00000000, q.nack, q.done, q.st == mop_pkg::H_WAIT};
            mop_pkg::A_RDATA: d.prdata = {16'h0000, q.rdata};
            default: ;
         endcase
      end
      // wait for the answer then release the request
      unique case (q.st)
         mop_pkg::H_IDLE: ;
         mop_pkg::H_WAIT: begin
            if (link.ack || link.nack) begin
               d.req = 1'b0;
               d.st = mop_pkg::H_IDLE;
               d.done = 1'b1;
               d.nack = link.nack; // RULE1
               if (link.ack) begin
                  d.rdata = link.rdata;
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= '0;
         q.st <= mop_pkg::H_IDLE;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state, except pready tied high
   assign prdata = q.prdata;
   assign pready = 1'b1;
   assign pslverr = q.pslverr;
   assign link.req = q.req;
   assign link.wr = q.ctrl[mop_pkg::C_WRITE];
   assign link.code = q.code;
   assign link.wdata = q.wdata;
   assign link.pec_present = q.ctrl[mop_pkg::C_PEC]; // RULE1
   assign link.pec_ok = q.ctrl[mop_pkg::C_PEC_OK];
endmodule : mop_host

// file: verif/mop_link_chk.sv
// link protocol checker beside the host-to-converter interface
module mop_link_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // link signals
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] code,
   input wire logic [15:0] wdata,
   input wire logic pec_present,
   input wire logic pec_ok,
   input wire logic ack,
   input wire logic nack,
   input wire logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   logic take, ok;
   logic [15:0] misc_q, ovr_q;
   // frame taken, and whether its checksum meets the policy
   assign take = req && !ack && !nack;
   assign ok = pec_present ? pec_ok : !misc_q[15];
   // shadow of both stored words
   always_ff @(posedge clock) begin
      if (rst) begin
         misc_q <= mop_pkg::MISC_RESET;
         ovr_q <= mop_pkg::OVR_RESET;
      end else if (take && wr && ok) begin
         if (code == mop_pkg::CMD_MISC) misc_q <= wdata;
         if (code == mop_pkg::CMD_OVR) ovr_q <= wdata;
      end
   end
   a_answer_next: assert property (take |=> ack ^ nack)
      else $error("frame not answered");
   a_answer_once: assert property (ack || nack |=> !ack && !nack)
      else $error("answer too long");
   a_req_release: assert property (ack || nack |=> !req)
      else $error("request kept");
   a_req_held: assert property (take |=> req && $stable(code) && $stable(wdata))
      else $error("request changed");
   a_pec_reject: assert property (take && !ok |=> nack)
      else $error("checksum not refused");
   a_word_accept: assert property (take && ok && code inside {8'hED, 8'hEE} |=> ack)
      else $error("word refused");
   a_misc_word: assert property (take && ok && code == 8'hED |=> rdata == $past(misc_q))
      else $error("options word wrong");
   a_ovr_word: assert property (take && ok && code == 8'hEE |=> rdata == $past(ovr_q))
      else $error("override word wrong");
   a_code_refuse: assert property (take && !(code inside {8'hED, 8'hEE, 8'h21}) |=> nack)
      else $error("unknown code taken");
   a_rdata_hold: assert property (!ack && !nack |-> $stable(rdata))
      else $error("read word moved");
   // main transfers seen
   c_write: cover property (take && wr ##1 ack);
   c_read: cover property (take && !wr ##1 ack);
   c_reject: cover property (take && !ok ##1 nack);
endmodule : mop_link_chk

// file: verif/test_misc_options_pin_override_regs.sv
// bench: APB host end and converter end joined over the link
module test_misc_options_pin_override_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [71:0] STRAP = 72'h5A5B5C5D5E5F606162;
   localparam logic [71:0] NVM = 72'hC0C1C2C3C4C5C6C7C8;
   typedef struct packed {
      logic [15:0] misc;
      logic [3:0] adc;
      logic pu;
      logic dec;
   } mop_row_s;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd, st;
   logic pready, pslverr, err;
   logic shutdown_evt = 1'b0, fault_restart_evt = 1'b0, retry_mode = 1'b1;
   logic power_good_output = 1'b1, reset_request = 1'b0, pwm_cycle = 1'b0;
   logic pwm_fault = 1'b0, clr_coms_fail = 1'b0, restore_evt = 1'b0;
   logic [71:0] strap_val = STRAP;
   logic [71:0] loaded_val;
   logic [15:0] output_voltage_override_command, prev;
   logic coms_fail, pin_o, pin_oe_n, pin_pullup_en, fault_tally_decay_mode;
   logic [1:0] telemetry_resolution;
   logic [3:0] adc_bits;
   logic [mop_pkg::TALLY_W-1:0] fault_tally;
   int bad_count = 0;
   int n_compared = 0;
   mop_row_s rows [4] = '{'{16'h0000, 4'hC, 1'b0, 1'b0}, '{16'h1001, 4'hA, 1'b1, 1'b0},
      '{16'h100A, 4'h8, 1'b0, 1'b0}, '{16'h0007, 4'h6, 1'b0, 1'b1}};
   logic [15:0] ovs [3] = '{16'h1B2F, 16'h0A05, 16'h1120};
   mop_link_if link ();
   mop_host u_mop_host (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .link(link));
   mop_device u_mop_device (.clock, .rst, .link(link), .shutdown_evt, .fault_restart_evt,
      .retry_mode, .boot_voltage_value(16'h0ABC), .power_good_output, .reset_request,
      .pwm_cycle, .pwm_fault, .clr_coms_fail, .restore_evt, .strap_val, .nvm_val(NVM),
      .output_voltage_override_command, .coms_fail, .pin_o, .pin_oe_n, .pin_pullup_en, .telemetry_resolution,
      .adc_bits, .fault_tally_decay_mode, .fault_tally, .loaded_val);
   mop_link_chk u_mop_link_chk (.clock, .rst, .req(link.req), .wr(link.wr), .code(link.code),
      .wdata(link.wdata), .pec_present(link.pec_present), .pec_ok(link.pec_ok),
      .ack(link.ack), .nack(link.nack), .rdata(link.rdata));
   // free-running clock
   always #5 clock = ~clock;
   // compare, verdict and helpers
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   function automatic logic [71:0] pick(input logic [15:0] o);
      logic [71:0] r;
      for (int k = 0; k < mop_pkg::NSET; k++)
         r[k*8 +: 8] = o[mop_pkg::OVR_BIT[k]] ? STRAP[k*8 +: 8] : NVM[k*8 +: 8];
      return r;
   endfunction : pick
   // one APB transfer; answer sampled settled, taken at the edge that sees pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      logic rdy;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      i = 0;
      do begin
         #1;
         rdy = pready;
         rd = prdata;
         err = pslverr;
         @(posedge clock);
         i++;
      end while (rdy !== 1'b1 && i < 50);
      if (i >= 50) begin
         bad_count++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one link word: pc is {checksum good, checksum present}
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
      input logic [1:0] pc);
      int i;
      apb(1'b1, mop_pkg::A_CODE, {24'h000000, c});
      apb(1'b1, mop_pkg::A_WDATA, {16'h0000, d});
      apb(1'b1, mop_pkg::A_CTRL, {28'h0000000, pc, w, 1'b1});
      i = 0;
      do begin
         apb(1'b0, mop_pkg::A_STATUS, 32'h00000000);
         i++;
      end while (rd[0] !== 1'b0 && i < 20);
      if (i >= 20) begin
         bad_count++;
         final_report();
      end
      st = rd;
      apb(1'b0, mop_pkg::A_RDATA, 32'h00000000);
   endtask : xfer
   task automatic pwm(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge clock);
         pwm_cycle <= !pwm_cycle;
      end
      tick(2);
   endtask : pwm
   // main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      tick(3);
      check(adc_bits, 4'hC);
      check(pin_oe_n, 1'b1);
      check(loaded_val, NVM);
      prev = mop_pkg::MISC_RESET;
      foreach (rows[k]) begin
         xfer(1'b1, mop_pkg::CMD_MISC, rows[k].misc, 2'b11);
         check(rd[15:0], prev);
         tick(2);
         check(adc_bits, rows[k].adc);
         check(telemetry_resolution, rows[k].misc[1:0]);
         check(pin_pullup_en, rows[k].pu);
         check(fault_tally_decay_mode, rows[k].dec);
         prev = rows[k].misc;
      end
      // pin roles: power good, then reset output
      @(posedge clock);
      power_good_output <= 1'b0;
      tick(3);
      check(pin_oe_n, 1'b0);
      xfer(1'b1, mop_pkg::CMD_MISC, 16'h1000, 2'b11);
      tick(2);
      check(pin_oe_n, 1'b1);
      @(posedge clock);
      reset_request <= 1'b1;
      tick(3);
      check(pin_oe_n, 1'b0);
      check(pin_o, 1'b0);
      @(posedge clock);
      reset_request <= 1'b0;
      power_good_output <= 1'b1;
      // checksum policy
      xfer(1'b1, mop_pkg::CMD_MISC, 16'h8000, 2'b11);
      xfer(1'b1, mop_pkg::CMD_MISC, 16'h0000, 2'b00);
      check(st[2], 1'b1);
      check(coms_fail, 1'b1);
      @(posedge clock);
      clr_coms_fail <= 1'b1;
      @(posedge clock);
      clr_coms_fail <= 1'b0;
      xfer(1'b1, mop_pkg::CMD_MISC, 16'h0000, 2'b11);
      check(rd[15:0], 16'h8000);
      xfer(1'b0, mop_pkg::CMD_MISC, 16'h0000, 2'b00);
      check(st[2], 1'b0);
      check(coms_fail, 1'b0);
      // setpoint reload on shutdown and on retry restart
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, mop_pkg::CMD_OUTPUT_VOLTAGE_OVERRIDE, 16'h1234, 2'b11);
         xfer(1'b1, mop_pkg::CMD_MISC, i[0] ? (i[1] ? 16'h2000 : 16'h4000) : 16'h0000, 2'b11);
         @(posedge clock);
         if (i[1]) fault_restart_evt <= 1'b1;
         else shutdown_evt <= 1'b1;
         @(posedge clock);
         fault_restart_evt <= 1'b0;
         shutdown_evt <= 1'b0;
         tick(2);
         check(output_voltage_override_command, i[0] ? 16'h0ABC : 16'h1234);
      end
      // no reload on fault restart when the response is not retry
      xfer(1'b1, mop_pkg::CMD_OUTPUT_VOLTAGE_OVERRIDE, 16'h1234, 2'b11);
      @(posedge clock);
      retry_mode <= 1'b0;
      fault_restart_evt <= 1'b1;
      @(posedge clock);
      fault_restart_evt <= 1'b0;
      tick(2);
      check(output_voltage_override_command, 16'h1234);
      // fault tally: count up, decrement, clear
      @(posedge clock);
      pwm_fault <= 1'b1;
      pwm(3);
      check(fault_tally, 8'h03);
      @(posedge clock);
      pwm_fault <= 1'b0;
      pwm(1);
      check(fault_tally, 8'h02);
      xfer(1'b1, mop_pkg::CMD_MISC, 16'h0004, 2'b11);
      pwm(1);
      check(fault_tally, 8'h00);
      // strap sources: strap changes after power-up must not be seen
      @(posedge clock);
      strap_val <= ~STRAP;
      prev = mop_pkg::OVR_RESET;
      foreach (ovs[k]) begin
         xfer(1'b1, mop_pkg::CMD_OVR, ovs[k], 2'b11);
         check(rd[15:0], prev);
         check(loaded_val, pick(prev));
         @(posedge clock);
         restore_evt <= 1'b1;
         @(posedge clock);
         restore_evt <= 1'b0;
         tick(2);
         check(loaded_val, pick(ovs[k]));
         prev = ovs[k];
      end
      // unmapped offset and unknown command
      apb(1'b0, 8'h14, 32'h00000000);
      check(err, 1'b1);
      xfer(1'b0, 8'h00, 16'h0000, 2'b11);
      check(st[2], 1'b1);
      // host clears reserved bits before a word goes out
      apb(1'b1, mop_pkg::A_CODE, {24'h000000, mop_pkg::CMD_MISC});
      apb(1'b1, mop_pkg::A_WDATA, 32'h0000FFFF);
      apb(1'b0, mop_pkg::A_WDATA, 32'h00000000);
      check(rd[15:0], 16'hF00F);
      apb(1'b1, mop_pkg::A_CODE, {24'h000000, mop_pkg::CMD_OVR});
      apb(1'b1, mop_pkg::A_WDATA, 32'h0000FFFF);
      apb(1'b0, mop_pkg::A_WDATA, 32'h00000000);
      check(rd[15:0], 16'h1F3F);
      // mid-run reset returns registers and outputs to their reset state
      @(posedge clock);
      rst <= 1'b1;
      tick(2);
      @(posedge clock);
      rst <= 1'b0;
      tick(3);
      check(output_voltage_override_command, mop_pkg::OUTPUT_VOLTAGE_OVERRIDE_RESET);
      check(adc_bits, 4'hC);
      check(pin_pullup_en, 1'b0);
      check(loaded_val, NVM);
      final_report();
   end
endmodule : test_misc_options_pin_override_regs
